// ---- hdl/pdcs_consts.vh ----
`ifndef PDCS_CONSTS_VH
`define PDCS_CONSTS_VH
// Register byte offsets on APB
`define PDCS_OFS_TX_FLAGS 12'h000
`define PDCS_OFS_TX_LEN 12'h004
`define PDCS_OFS_TX_COMP 12'h008
`define PDCS_OFS_RX_SKIP 12'h00C
`define PDCS_OFS_IRQ_STAT 12'h010
`define PDCS_OFS_IRQ_MASK 12'h014
// Field positions
`define PDCS_TAG_HI 31
`define PDCS_TAG_LO 24
`define PDCS_LAST_BIT 17
`define PDCS_FIRST_BIT 16
`define PDCS_LEN_HI 15
`define PDCS_REM_HI 31
`define PDCS_REM_LO 16
`define PDCS_KIND_BIT 0
// Interrupt status bit positions
`define PDCS_EV_QUEUE 0
`define PDCS_EV_TRUNC 1
`define PDCS_EV_DONE 2
// Reset values
`define PDCS_RST_WORD 32'h00000000
`define PDCS_RST_SKIP 8'h00
`define PDCS_RST_IRQ 3'h0
// Timing: APB answers with no wait state
`define PDCS_APB_WAIT 1'b1
`endif

// ---- hdl/pdcs_comp_ptr.v ----
`timescale 1ns/1ps
`include "pdcs_consts.vh"
// Completion pointer with compare/write-back queue interrupt
module pdcs_comp_ptr (
  input wire ref_clk,
  input wire sys_rst,
  input wire sw_wr,
  input wire [31:0] sw_wdata,
  input wire hw_done,
  input wire [29:0] hw_addr,
  output reg [29:0] last_done_descriptor,
  output reg queue_irq
);
  // Mode bit of the write selects compare or write-back
  wire completion_write_kind;
  assign completion_write_kind = sw_wdata[`PDCS_KIND_BIT];

  // Pointer and level interrupt; write-back assertion beats a clear
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      last_done_descriptor <= 30'h00000000;
      queue_irq <= 1'b0;
    end
    else if (hw_done)
    begin
      // Hardware records the last finished descriptor and raises the queue
      last_done_descriptor <= hw_addr;
      queue_irq <= 1'b1;
    end
    else if (sw_wr && completion_write_kind)
    begin
      last_done_descriptor <= sw_wdata[31:2];
      queue_irq <= 1'b1;
    end
    else if (sw_wr && (sw_wdata[31:2] == last_done_descriptor))
    begin
      // Compare hit drops the level, pointer unchanged
      queue_irq <= 1'b0;
    end
  end
endmodule // pdcs_comp_ptr

// ---- hdl/pdcs_rx_skip.v ----
`timescale 1ns/1ps
`include "pdcs_consts.vh"
// Skips the programmed bytes at the start of the first receive buffer
module pdcs_rx_skip (
  input wire ref_clk,
  input wire sys_rst,
  input wire [7:0] first_buffer_skip,
  input wire rx_first_of_packet,
  input wire rx_byte_valid,
  output wire rx_byte_write,
  output reg [7:0] rx_skip_left
);
  // Bytes are discarded while the skip count is nonzero
  assign rx_byte_write = rx_byte_valid && (rx_skip_left == 8'h00) && !rx_first_of_packet;

  // Count loads at packet start, counts down per received byte
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      rx_skip_left <= `PDCS_RST_SKIP;
    else if (rx_first_of_packet)
      rx_skip_left <= first_buffer_skip;
    else if (rx_byte_valid && (rx_skip_left != 8'h00))
      rx_skip_left <= rx_skip_left - 8'h01;
  end
endmodule // pdcs_rx_skip

// ---- hdl/pdcs_top.v ----
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "pdcs_consts.vh"
module pdcs_top (
  input wire ref_clk,
  input wire sys_rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Transmit descriptor side
  input wire tx_desc_load,
  input wire tx_desc_first,
  input wire tx_desc_last,
  input wire [7:0] tx_desc_tag,
  input wire [15:0] tx_desc_buf_len,
  input wire [15:0] tx_desc_pkt_len,
  input wire tx_byte_sent,
  input wire tx_pkt_done,
  input wire [29:0] tx_pkt_last_done_descriptor,
  output wire tx_byte_allowed,
  output reg [7:0] rx_packet_tag_byte,
  output reg [15:0] trailer_length,
  // Receive side
  input wire rx_first_of_packet,
  input wire rx_byte_valid,
  output wire rx_byte_write,
  output wire irq
);
  // Transmit state fields
  reg [7:0] packet_tag_byte;
  reg buffer_is_last;
  reg buffer_is_first;
  reg [15:0] buffer_bytes_left;
  reg [15:0] packet_bytes_left;
  reg [15:0] packet_length;
  reg [7:0] first_buffer_skip;
  reg [2:0] irq_stat;
  reg [2:0] irq_mask;
  wire [29:0] last_done_descriptor;
  wire queue_irq;
  wire [7:0] rx_skip_left;

  // Decode helper used for every register select
  function sel_hit;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      sel_hit = (addr == ofs);
    end
  endfunction

  // Bus strobes: zero wait states
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire wr_flags = wr && sel_hit(paddr, `PDCS_OFS_TX_FLAGS);
  wire wr_len = wr && sel_hit(paddr, `PDCS_OFS_TX_LEN);
  wire wr_comp = wr && sel_hit(paddr, `PDCS_OFS_TX_COMP);
  wire wr_skip = wr && sel_hit(paddr, `PDCS_OFS_RX_SKIP);
  wire wr_stat = wr && sel_hit(paddr, `PDCS_OFS_IRQ_STAT);
  wire wr_mask = wr && sel_hit(paddr, `PDCS_OFS_IRQ_MASK);
  wire mapped = sel_hit(paddr, `PDCS_OFS_TX_FLAGS) || sel_hit(paddr, `PDCS_OFS_TX_LEN) ||
    sel_hit(paddr, `PDCS_OFS_TX_COMP) || sel_hit(paddr, `PDCS_OFS_RX_SKIP) ||
    sel_hit(paddr, `PDCS_OFS_IRQ_STAT) || sel_hit(paddr, `PDCS_OFS_IRQ_MASK);
  assign pready = `PDCS_APB_WAIT;
  // Unmapped addresses answer with an error, reading zero
  assign pslverr = acc && !mapped;

  // Bytes may go only while both buffer and packet still have some
  assign tx_byte_allowed = (buffer_bytes_left != 16'h0000) &&
    (packet_bytes_left != 16'h0000);
  wire moved = tx_byte_sent && tx_byte_allowed;
  // Truncation event: buffer had data but packet count ran out
  wire trunc_ev = tx_byte_sent && (buffer_bytes_left != 16'h0000) &&
    (packet_bytes_left == 16'h0000);

  // Descriptor load, byte countdown and software writes of state words
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      packet_tag_byte <= 8'h00;
      buffer_is_last <= 1'b0;
      buffer_is_first <= 1'b0;
      buffer_bytes_left <= 16'h0000;
      packet_bytes_left <= 16'h0000;
      packet_length <= 16'h0000;
    end
    else if (tx_desc_load)
    begin
      // New buffer; first buffer also reloads packet-wide state
      buffer_is_last <= tx_desc_last;
      buffer_is_first <= tx_desc_first;
      buffer_bytes_left <= tx_desc_buf_len;
      if (tx_desc_first)
      begin
        packet_tag_byte <= tx_desc_tag;
        packet_length <= tx_desc_pkt_len;
        packet_bytes_left <= tx_desc_pkt_len;
      end
    end
    else if (moved)
    begin
      buffer_bytes_left <= buffer_bytes_left - 16'h0001;
      packet_bytes_left <= packet_bytes_left - 16'h0001;
    end
    else
    begin
      // Software may restore state words, except buffer_is_last, while idle
      if (wr_flags)
      begin
        packet_tag_byte <= pwdata[`PDCS_TAG_HI:`PDCS_TAG_LO];
        buffer_is_first <= pwdata[`PDCS_FIRST_BIT];
        buffer_bytes_left <= pwdata[`PDCS_LEN_HI:0];
      end
      if (wr_len)
      begin
        packet_bytes_left <= pwdata[`PDCS_REM_HI:`PDCS_REM_LO];
        packet_length <= pwdata[`PDCS_LEN_HI:0];
      end
    end
  end

  // Data outputs to trailer builder and receive descriptor writer
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_packet_tag_byte <= 8'h00;
      trailer_length <= 16'h0000;
    end
    else if (tx_pkt_done)
    begin
      rx_packet_tag_byte <= packet_tag_byte;
      trailer_length <= packet_length;
    end
  end

  // Receive skip setting, software programs it at channel setup
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      first_buffer_skip <= `PDCS_RST_SKIP;
    else if (wr_skip)
      first_buffer_skip <= pwdata[7:0];
  end

  // Sticky events: set wins over write-one-to-clear
  wire [2:0] ev = {tx_pkt_done, trunc_ev, queue_irq};
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_stat <= `PDCS_RST_IRQ;
      irq_mask <= `PDCS_RST_IRQ;
    end
    else
    begin
      irq_stat <= ev | (irq_stat & ~(wr_stat ? pwdata[2:0] : 3'h0));
      if (wr_mask)
        irq_mask <= pwdata[2:0];
    end
  end
  assign irq = |(irq_stat & irq_mask);

  // Completion pointer holds the queue interrupt level
  pdcs_comp_ptr u_comp (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .sw_wr(wr_comp),
    .sw_wdata(pwdata),
    .hw_done(tx_pkt_done),
    .hw_addr(tx_pkt_last_done_descriptor),
    .last_done_descriptor(last_done_descriptor),
    .queue_irq(queue_irq)
  );

  // Receive byte gating for the first buffer
  pdcs_rx_skip u_skip (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .first_buffer_skip(first_buffer_skip),
    .rx_first_of_packet(rx_first_of_packet),
    .rx_byte_valid(rx_byte_valid),
    .rx_byte_write(rx_byte_write),
    .rx_skip_left(rx_skip_left)
  );

  // Read mux, registered in the setup phase so data is ready at access
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      prdata <= `PDCS_RST_WORD;
    else if (psel && !penable && !pwrite)
    begin
      if (sel_hit(paddr, `PDCS_OFS_TX_FLAGS))
        prdata <= {packet_tag_byte, 6'h00, buffer_is_last, buffer_is_first, buffer_bytes_left};
      else if (sel_hit(paddr, `PDCS_OFS_TX_LEN))
        prdata <= {packet_bytes_left, packet_length};
      else if (sel_hit(paddr, `PDCS_OFS_TX_COMP))
        prdata <= {last_done_descriptor, 2'h0};
      else if (sel_hit(paddr, `PDCS_OFS_RX_SKIP))
        prdata <= {24'h000000, first_buffer_skip};
      else if (sel_hit(paddr, `PDCS_OFS_IRQ_STAT))
        prdata <= {29'h00000000, irq_stat};
      else if (sel_hit(paddr, `PDCS_OFS_IRQ_MASK))
        prdata <= {29'h00000000, irq_mask};
      else
        prdata <= `PDCS_RST_WORD;
    end
  end
endmodule // pdcs_top

// ---- verif/pdcs_properties.sv ----
`timescale 1ns/1ps
// Checker on the top ports; helpers mirror descriptor and mask state
module pdcs_properties (
  input wire ref_clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire tx_desc_load,
  input wire tx_desc_first,
  input wire [7:0] tx_desc_tag,
  input wire [15:0] tx_desc_buf_len,
  input wire [15:0] tx_desc_pkt_len,
  input wire tx_pkt_done,
  input wire tx_byte_allowed,
  input wire [7:0] rx_packet_tag_byte,
  input wire [15:0] trailer_length,
  input wire rx_first_of_packet,
  input wire rx_byte_write,
  input wire irq
);
  reg [7:0] tag; // Tag of the latest first descriptor
  reg [15:0] len; // Its packet length
  reg [2:0] msk; // Mirror of the mask register
  wire wr = psel && penable && pwrite; // Write takes effect
  wire rs = psel && !penable && !pwrite; // Read setup
  // Mirrors update on the same edge as the design
  always @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      tag <= 8'h00;
      len <= 16'h0000;
      msk <= 3'h0;
    end
    else
    begin
      if (tx_desc_load && tx_desc_first)
      begin
        tag <= tx_desc_tag;
        len <= tx_desc_pkt_len;
      end
      if (wr && paddr == 12'h014)
        msk <= pwdata[2:0];
    end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  AST_TAG: assert property (tx_pkt_done |=> rx_packet_tag_byte == tag)
    else $error("tag not carried");
  AST_TRAILER: assert property (tx_pkt_done |=> trailer_length == len)
    else $error("trailer length wrong");
  AST_LOAD: assert property (tx_desc_load && tx_desc_first &&
    tx_desc_buf_len != 16'h0000 && tx_desc_pkt_len != 16'h0000 |=> tx_byte_allowed)
    else $error("loaded buffer not sendable");
  AST_MODE: assert property (rs && paddr == 12'h008 |=> prdata[1:0] == 2'b00)
    else $error("mode bit read back");
  // Queue level rises one edge after the write, the status bit one edge later
  AST_WB: assert property (wr && paddr == 12'h008 && pwdata[0] && msk[0] |-> ##2 irq)
    else $error("write-back left irq low");
  AST_MASK: assert property (msk == 3'h0 |-> !irq)
    else $error("irq while masked");
  AST_SKIP: assert property (rx_first_of_packet |-> !rx_byte_write)
    else $error("byte written in load cycle");
  AST_ERR: assert property (psel && penable && paddr > 12'h014 |-> pslverr && pready)
    else $error("unmapped access accepted");
  cover property (tx_pkt_done);
  cover property (irq ##1 !irq);
  cover property (rx_byte_write);
endmodule // pdcs_properties
bind pdcs_top pdcs_properties u_props (.*);

// ---- verif/pdcs_mem_model.sv ----
`timescale 1ns/1ps
// Memory side: hands descriptor words and byte strobes to the channel
module pdcs_mem_model (
  input wire ref_clk,
  output reg tx_desc_load,
  output reg tx_desc_first,
  output reg tx_desc_last,
  output reg [7:0] tx_desc_tag,
  output reg [15:0] tx_desc_buf_len,
  output reg [15:0] tx_desc_pkt_len,
  output reg tx_byte_sent,
  output reg tx_pkt_done,
  output reg [29:0] tx_pkt_last_done_descriptor
);
  initial
  begin
    {tx_desc_load, tx_byte_sent, tx_pkt_done} = 3'h0;
    {tx_desc_first, tx_desc_last, tx_desc_tag, tx_desc_buf_len, tx_desc_pkt_len} = 42'h0;
    tx_pkt_last_done_descriptor = 30'h0;
  end
  // One descriptor, valid for one cycle; afterwards the bus shows junk
  task desc(input f, input l, input [7:0] t, input [15:0] b, input [15:0] p);
    begin
      @(posedge ref_clk);
      tx_desc_load <= 1'b1;
      {tx_desc_first, tx_desc_last, tx_desc_tag, tx_desc_buf_len, tx_desc_pkt_len} <= {f, l, t, b, p};
      @(posedge ref_clk);
      tx_desc_load <= 1'b0;
      {tx_desc_first, tx_desc_last, tx_desc_tag, tx_desc_buf_len, tx_desc_pkt_len} <= ~{f, l, t, b, p};
    end
  endtask
  // Back-to-back byte strobes
  task bytes(input [7:0] n);
    begin
      repeat (n) @(posedge ref_clk) tx_byte_sent <= 1'b1;
      @(posedge ref_clk);
      tx_byte_sent <= 1'b0;
    end
  endtask
  // End of packet with the last descriptor's word address
  task done(input [29:0] a);
    begin
      @(posedge ref_clk);
      tx_pkt_done <= 1'b1;
      tx_pkt_last_done_descriptor <= a;
      @(posedge ref_clk);
      tx_pkt_done <= 1'b0;
      tx_pkt_last_done_descriptor <= ~a;
    end
  endtask
endmodule // pdcs_mem_model

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`define CK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  reg ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, d;
  reg rx_first_of_packet = 1'b0, rx_byte_valid = 1'b0, se;
  wire [31:0] prdata;
  wire pready, pslverr, tx_byte_allowed, rx_byte_write, irq;
  wire tx_desc_load, tx_desc_first, tx_desc_last, tx_byte_sent, tx_pkt_done;
  wire [7:0] tx_desc_tag, rx_packet_tag_byte;
  wire [15:0] tx_desc_buf_len, tx_desc_pkt_len, trailer_length;
  wire [29:0] tx_pkt_last_done_descriptor;
  integer err_total = 0, comparisons = 0, i, n;
  always #10 ref_clk = ~ref_clk;
  pdcs_top dut (.*);
  pdcs_mem_model mem (.*);
  // One APB transfer; waits for pready, takes data at that edge
  task acc(input w, input [11:0] a, input [31:0] v);
    begin
      @(posedge ref_clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, v};
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      d = prdata;
      se = pslverr;
      {psel, penable} <= 2'b00;
    end
  endtask
  task rc(input [11:0] a, input [31:0] e);
    begin
      acc(1'b0, a, 32'h0);
      `CK("read", e, d)
    end
  endtask
  task end_of_test;
    begin
      $display("Compares %0d, errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // Hang guard, well past the expected run
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    err_total++;
    end_of_test;
  end
  initial
  begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 6; i++) rc(i * 4, 32'h0);
    acc(1'b0, 12'h018, 32'h0);
    `CK("unmapped", 1'b1, se)
    acc(1'b1, 12'h00C, 32'h3);
    @(posedge ref_clk) rx_first_of_packet <= 1'b1;
    @(posedge ref_clk) {rx_first_of_packet, rx_byte_valid} <= 2'b01;
    n = 0;
    repeat (5) @(negedge ref_clk) n = n + rx_byte_write;
    @(posedge ref_clk) rx_byte_valid <= 1'b0;
    `CK("skip", 2, n)
    mem.desc(1'b1, 1'b0, 8'hA5, 16'h2, 16'h3);
    rc(12'h000, 32'hA5010002);
    rc(12'h004, 32'h00030003);
    mem.bytes(2);
    @(negedge ref_clk) `CK("allow", 1'b0, tx_byte_allowed)
    rc(12'h004, 32'h00010003);
    mem.desc(1'b0, 1'b1, 8'h3C, 16'h4, 16'h9);
    rc(12'h000, 32'hA5020004);
    mem.bytes(2);
    rc(12'h000, 32'hA5020003);
    `CK("allow", 1'b0, tx_byte_allowed)
    mem.done(30'h1234);
    // Captured registers update at the edge that ends the pulse; look once they settle
    @(negedge ref_clk) `CK("tag", 8'hA5, rx_packet_tag_byte)
    `CK("trailer", 16'h3, trailer_length)
    rc(12'h008, 32'h000048D0);
    rc(12'h010, 32'h7);
    acc(1'b1, 12'h014, 32'h1);
    acc(1'b1, 12'h008, 32'h000048D4);
    acc(1'b1, 12'h010, 32'h7);
    rc(12'h008, 32'h000048D0);
    `CK("irq", 1'b1, irq)
    acc(1'b1, 12'h008, 32'h000048D0);
    acc(1'b1, 12'h010, 32'h7);
    @(negedge ref_clk) `CK("irq", 1'b0, irq)
    acc(1'b1, 12'h008, 32'h00000103);
    rc(12'h008, 32'h00000100);
    `CK("irq", 1'b1, irq)
    acc(1'b1, 12'h014, 32'h0);
    @(negedge ref_clk) `CK("irq", 1'b0, irq)
    end_of_test;
  end
endmodule // tb
